// [hw/tsc_cycle_control.sv]
// Touch sensing cycle scheduler, calibration sequencer and touch interrupt gating
//
// Behaviour
// - Sample count per channel 1..128, default eight
// - Samples back to back, then average, update
// - Sample duration 320us..2.56ms, default 1.28ms
// - Cycle period 35..140ms, default 70ms
// - Sample enabled channels, then low power
// - Long sampling stretches cycle, count has priority
// - Host writing one requests input calibration
// - Finished calibration updates stored 10-bit value
// - Successful calibration clears its request bit
// - Uncleared request after calibration sets failure flag
// - Noise or limit value means calibration failed
// - Newly enabled input requests calibration automatically
// - Host writing zero drops pending calibration
// - Enabled touches drive active-low interrupt, default all
// - Bit 7 is input eight, bit 0 one
// - Active enable bit includes input in cycle
// - Failure flag raises interrupt only when enabled
`timescale 1ns/10ps
`include "tsc_map.svh"

module tsc_cycle_control
  import tsc_pkg::*;
#(
  parameter int P_SAMPLE_UNIT_CYCLES = `TSC_SAMPLE_UNIT_NS / `TSC_CLK_PERIOD_NS,
  parameter int P_CYCLE_UNIT_CYCLES  = `TSC_CYCLE_UNIT_NS / `TSC_CLK_PERIOD_NS
)
(
  input  wire logic        i_mclk,
  input  wire logic        i_reset,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic      [7:0]  o_reg_rdata,
  input  wire logic        i_wake,
  input  wire logic [15:0] i_sample_count,
  output logic             o_sample_start,
  output logic      [2:0]  o_sample_input,
  output logic             o_result_valid,
  output logic      [2:0]  o_result_input,
  output logic      [15:0] o_measured_result,
  output logic             o_low_power,
  output logic             o_cal_start,
  output logic      [2:0]  o_cal_input,
  input  wire logic        i_cal_done,
  input  wire logic [9:0]  i_cal_value,
  input  wire logic [7:0]  i_noise_flag,
  input  wire logic [2:0]  i_cal_read_input,
  output logic      [9:0]  o_stored_calibration_value,
  output logic             o_analog_calibration_failure_flag,
  input  wire logic        i_cal_fail_clear,
  input  wire logic        i_cal_fail_irq_enable,
  input  wire logic [7:0]  i_touch_status,
  output logic             o_alert_n
);

  tsc_ctrl_s   s;
  tsc_ctrl_s   next_s;

  logic        sample_load;
  logic [23:0] sample_load_value;
  logic        sample_expired;
  logic        cycle_load;
  logic [23:0] cycle_load_value;
  logic        cycle_expired;
  logic        store_we;
  logic [7:0]  cal_pending;
  logic [7:0]  channel_pending;
  logic [7:0]  dev_set;
  logic [7:0]  dev_clear;
  logic [7:0]  dev_tried;
  logic [7:0]  host_cal;
  logic        host_cal_wr;
  logic        cal_ok;
  logic [7:0]  last_sample;

  // ==========================================================================
  // Helpers

  // Lowest set bit gives input one first when several are pending
  function automatic logic [2:0] tsc_first_set(input logic [7:0] mask);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (mask[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction : tsc_first_set

  function automatic logic [7:0] tsc_read(input tsc_ctrl_s r, input logic [7:0] addr);
    logic [7:0] data;
    data = 8'h00;
    unique case (addr)
      `TSC_ADDR_ACTIVE_ENABLE:  data = r.active_enable;
      `TSC_ADDR_SAMPLING_SETUP: data = {1'b0, r.sampling_setup};
      `TSC_ADDR_CAL_REQUEST:    data = r.cal_request;
      `TSC_ADDR_TOUCH_IRQ_EN:   data = r.touch_irq_enable;
      default:                  data = 8'h00;
    endcase
    return data;
  endfunction : tsc_read

  // ==========================================================================
  // Timers and calibration store

  tsc_interval_timer u_sample_timer (
    .i_mclk       (i_mclk),
    .i_reset      (i_reset),
    .i_load       (sample_load),
    .i_load_value (sample_load_value),
    .o_expired    (sample_expired)
  );

  tsc_interval_timer u_cycle_timer (
    .i_mclk       (i_mclk),
    .i_reset      (i_reset),
    .i_load       (cycle_load),
    .i_load_value (cycle_load_value),
    .o_expired    (cycle_expired)
  );

  tsc_cal_store u_cal_store (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_we    (store_we),
    .i_waddr (s.cal_input),
    .i_wdata (i_cal_value),
    .i_raddr (i_cal_read_input),
    .o_rdata (o_stored_calibration_value)
  );

  // Each sample lasts 320us doubled per code step; one less for the re-arm cycle
  assign sample_load_value = (24'(P_SAMPLE_UNIT_CYCLES) << s.cur_duration_sel)
                             - 24'h000001;
  // Period is 35ms times code plus one; the registered expiry and the
  // start state cost two cycles, so they come off the load value
  assign cycle_load_value  = 24'(P_CYCLE_UNIT_CYCLES *
                                 (int'(s.sampling_setup[`TSC_PERIOD_SEL_MSB:
                                                        `TSC_PERIOD_SEL_LSB]) + 1) - 2);
  assign last_sample       = 8'((9'h001 << s.cur_count_sel) - 9'h001);
  assign cal_pending       = s.cal_request & ~s.cal_tried;
  assign channel_pending   = s.active_enable & ~s.visited;
  assign host_cal_wr       = i_reg_wr && (i_reg_addr == `TSC_ADDR_CAL_REQUEST);
  assign host_cal          = host_cal_wr ? i_reg_wdata : 8'h00;
  assign cal_ok            = !i_noise_flag[s.cal_input] &&
                             (i_cal_value != `TSC_CAL_VALUE_MAX) &&
                             (i_cal_value != `TSC_CAL_VALUE_MIN);

  // ==========================================================================
  // Next-state logic

  always_comb begin
    next_s       = s;
    sample_load  = 1'b0;
    cycle_load   = 1'b0;
    store_we     = 1'b0;
    dev_set      = 8'h00;
    dev_clear    = 8'h00;
    dev_tried    = 8'h00;
    next_s.sample_start = 1'b0;
    next_s.cal_start    = 1'b0;
    next_s.result_valid = 1'b0;
    next_s.fresh        = 1'b0;

    // Register port
    if (i_reg_rd) begin
      next_s.reg_rdata = tsc_read(s, i_reg_addr);
    end
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        `TSC_ADDR_ACTIVE_ENABLE: begin
          next_s.active_enable = i_reg_wdata;
          dev_set = i_reg_wdata & ~s.active_enable;
        end
        `TSC_ADDR_SAMPLING_SETUP: next_s.sampling_setup = i_reg_wdata[6:0];
        `TSC_ADDR_TOUCH_IRQ_EN:   next_s.touch_irq_enable = i_reg_wdata;
        default: ;
      endcase
    end
    // Power-on and wake request calibration of every active input anew
    if (s.fresh || i_wake) begin
      dev_set = dev_set | s.active_enable;
    end

    unique case (s.state)
      TSC_ST_CYCLE_START: begin
        // Timing fields are latched only here so a cycle never changes shape midway
        next_s.cur_count_sel    = s.sampling_setup[`TSC_COUNT_SEL_MSB:`TSC_COUNT_SEL_LSB];
        next_s.cur_duration_sel = s.sampling_setup[`TSC_DURATION_SEL_MSB:
                                                   `TSC_DURATION_SEL_LSB];
        next_s.cur_period_sel   = s.sampling_setup[`TSC_PERIOD_SEL_MSB:`TSC_PERIOD_SEL_LSB];
        cycle_load     = 1'b1;
        next_s.visited = 8'h00;
        next_s.state   = TSC_ST_CAL_CHECK;
      end

      TSC_ST_CAL_CHECK: begin
        if (cal_pending != 8'h00) begin
          next_s.cal_input = tsc_first_set(cal_pending);
          next_s.cal_start = 1'b1;
          next_s.state     = TSC_ST_CAL_WAIT;
        end else begin
          if (s.cal_ran && ((s.cal_request & s.cal_tried) != 8'h00)) begin
            next_s.fail_flag = 1'b1;
          end
          next_s.cal_ran = 1'b0;
          next_s.state   = TSC_ST_SELECT;
        end
      end

      TSC_ST_CAL_WAIT: begin
        if (i_cal_done) begin
          store_we = 1'b1;
          dev_tried[s.cal_input] = 1'b1;
          if (cal_ok) begin
            dev_clear[s.cal_input] = 1'b1;
          end
          next_s.cal_ran = 1'b1;
          next_s.state   = TSC_ST_CAL_CHECK;
        end
      end

      TSC_ST_SELECT: begin
        if (channel_pending == 8'h00) begin
          // Sampling ran past the period: start the next cycle at once
          next_s.state = cycle_expired ? TSC_ST_CYCLE_START : TSC_ST_IDLE;
        end else begin
          next_s.channel      = tsc_first_set(channel_pending);
          next_s.accum        = 23'h000000;
          next_s.sample_index = 8'h00;
          next_s.sample_start = 1'b1;
          sample_load         = 1'b1;
          next_s.state        = TSC_ST_SAMPLE;
        end
      end

      TSC_ST_SAMPLE: begin
        if (sample_expired) begin
          next_s.accum = s.accum + 23'(i_sample_count);
          if (s.sample_index == last_sample) begin
            next_s.state = TSC_ST_UPDATE;
          end else begin
            // Next sample stays on the same channel
            next_s.sample_index = s.sample_index + 8'h01;
            next_s.sample_start = 1'b1;
            sample_load         = 1'b1;
          end
        end
      end

      TSC_ST_UPDATE: begin
        next_s.result       = 16'(s.accum >> s.cur_count_sel);
        next_s.result_valid = 1'b1;
        next_s.visited[s.channel] = 1'b1;
        next_s.state        = TSC_ST_SELECT;
      end

      TSC_ST_IDLE: begin
        if (cycle_expired) begin
          next_s.state = TSC_ST_CYCLE_START;
        end
      end
    endcase

    next_s.low_power = (next_s.state == TSC_ST_IDLE);

    // Host value wins over a same-cycle device clear; device sets win over all
    next_s.cal_request = (host_cal_wr ? i_reg_wdata : (s.cal_request & ~dev_clear))
                         | dev_set;
    // A fresh request, from host or device, makes the input eligible again
    next_s.cal_tried   = (s.cal_tried | dev_tried) & ~host_cal & ~dev_set;

    if (i_cal_fail_clear && !(s.state == TSC_ST_CAL_CHECK && next_s.fail_flag)) begin
      next_s.fail_flag = 1'b0;
    end

    next_s.alert_n = !(((i_touch_status & s.touch_irq_enable) != 8'h00) ||
                       (s.fail_flag && i_cal_fail_irq_enable));

    if (i_reset) begin
      next_s                  = '0;
      next_s.state            = TSC_ST_CYCLE_START;
      next_s.active_enable    = `TSC_RST_ACTIVE_ENABLE;
      next_s.sampling_setup   = `TSC_RST_SAMPLING_SETUP;
      next_s.cal_request      = `TSC_RST_CAL_REQUEST;
      next_s.touch_irq_enable = `TSC_RST_TOUCH_IRQ_EN;
      next_s.fresh            = 1'b1;
      next_s.alert_n          = 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    s <= next_s;
  end

  // ==========================================================================
  // Outputs

  assign o_reg_rdata                       = s.reg_rdata;
  assign o_sample_start                    = s.sample_start;
  assign o_sample_input                    = s.channel;
  assign o_result_valid                    = s.result_valid;
  assign o_result_input                    = s.channel;
  assign o_measured_result                 = s.result;
  assign o_low_power                       = s.low_power;
  assign o_cal_start                       = s.cal_start;
  assign o_cal_input                       = s.cal_input;
  assign o_analog_calibration_failure_flag = s.fail_flag;
  assign o_alert_n                         = s.alert_n;

endmodule : tsc_cycle_control

// [shared/tsc_map.svh]
// Register offsets, field positions, reset values and timing constants of the touch cycle control
`ifndef TSC_MAP_SVH
`define TSC_MAP_SVH

// ==========================================================================
// Register offsets
`define TSC_ADDR_ACTIVE_ENABLE  8'h21
`define TSC_ADDR_SAMPLING_SETUP 8'h24
`define TSC_ADDR_CAL_REQUEST    8'h26
`define TSC_ADDR_TOUCH_IRQ_EN   8'h27

// ==========================================================================
// Reset values
`define TSC_RST_ACTIVE_ENABLE   8'hFF
`define TSC_RST_SAMPLING_SETUP  7'h39
`define TSC_RST_CAL_REQUEST     8'h00
`define TSC_RST_TOUCH_IRQ_EN    8'hFF

// ==========================================================================
// Field positions inside sampling_setup
`define TSC_COUNT_SEL_MSB       6
`define TSC_COUNT_SEL_LSB       4
`define TSC_DURATION_SEL_MSB    3
`define TSC_DURATION_SEL_LSB    2
`define TSC_PERIOD_SEL_MSB      1
`define TSC_PERIOD_SEL_LSB      0

// ==========================================================================
// Timing: shortest sample and shortest cycle period, clock period
`define TSC_CLK_PERIOD_NS       25
`define TSC_SAMPLE_UNIT_NS      320000
`define TSC_CYCLE_UNIT_NS       35000000

// ==========================================================================
// Calibration value limits
`define TSC_CAL_VALUE_MAX       10'h3FF
`define TSC_CAL_VALUE_MIN       10'h000

`endif

// [shared/tsc_pkg.sv]
// Types shared by the touch cycle control modules
package tsc_pkg;

  typedef enum logic [2:0] {
    TSC_ST_CYCLE_START,
    TSC_ST_CAL_CHECK,
    TSC_ST_CAL_WAIT,
    TSC_ST_SELECT,
    TSC_ST_SAMPLE,
    TSC_ST_UPDATE,
    TSC_ST_IDLE
  } tsc_state_e;

  typedef struct packed {
    tsc_state_e  state;
    logic [7:0]  active_enable;
    logic [6:0]  sampling_setup;
    logic [7:0]  cal_request;
    logic [7:0]  touch_irq_enable;
    logic [7:0]  cal_tried;
    logic        cal_ran;
    logic        fail_flag;
    logic        fresh;
    logic [2:0]  cur_count_sel;
    logic [1:0]  cur_duration_sel;
    logic [1:0]  cur_period_sel;
    logic [2:0]  channel;
    logic [7:0]  visited;
    logic [7:0]  sample_index;
    logic [22:0] accum;
    logic [7:0]  reg_rdata;
    logic        sample_start;
    logic        result_valid;
    logic [15:0] result;
    logic        cal_start;
    logic [2:0]  cal_input;
    logic        low_power;
    logic        alert_n;
  } tsc_ctrl_s;

  typedef struct packed {
    logic [23:0] count;
    logic        expired;
  } tsc_timer_s;

  typedef struct packed {
    logic [7:0][9:0] cells;
    logic [9:0]      rdata;
  } tsc_store_s;

endpackage : tsc_pkg

// [hw/tsc_interval_timer.sv]
// Down-counting interval timer with a registered expiry flag
`timescale 1ns/10ps

module tsc_interval_timer
  import tsc_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_reset,
  input  wire logic        i_load,
  input  wire logic [23:0] i_load_value,
  output logic             o_expired
);

  tsc_timer_s s;
  tsc_timer_s next_s;

  // Expiry rises i_load_value cycles after the load edge and then holds
  always_comb begin
    next_s = s;
    if (i_reset) begin
      next_s.count   = 24'h000000;
      next_s.expired = 1'b0;
    end else if (i_load) begin
      next_s.count   = i_load_value;
      next_s.expired = 1'b0;
    end else if (s.count != 24'h000000) begin
      next_s.count   = s.count - 24'h000001;
      next_s.expired = (s.count == 24'h000001);
    end
  end

  always_ff @(posedge i_mclk) begin
    s <= next_s;
  end

  assign o_expired = s.expired;

endmodule : tsc_interval_timer

// [hw/tsc_cal_store.sv]
// Eight stored 10-bit calibration values with a registered read port
`timescale 1ns/10ps

module tsc_cal_store
  import tsc_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_reset,
  input  wire logic       i_we,
  input  wire logic [2:0] i_waddr,
  input  wire logic [9:0] i_wdata,
  input  wire logic [2:0] i_raddr,
  output logic      [9:0] o_rdata
);

  tsc_store_s s;
  tsc_store_s next_s;

  always_comb begin
    next_s = s;
    if (i_reset) begin
      next_s = '0;
    end else begin
      if (i_we) begin
        next_s.cells[i_waddr] = i_wdata;
      end
      // Read shows the old value in the write cycle, the new one a cycle later
      next_s.rdata = s.cells[i_raddr];
    end
  end

  always_ff @(posedge i_mclk) begin
    s <= next_s;
  end

  assign o_rdata = s.rdata;

endmodule : tsc_cal_store

// [verification/tsc_cycle_control_asserts.sv]
// Port-level assertions for the touch cycle control
`timescale 1ns/10ps

module tsc_cycle_control_asserts (
  input wire logic       i_mclk,
  input wire logic       i_reset,
  input wire logic       o_sample_start,
  input wire logic [2:0] o_sample_input,
  input wire logic       o_low_power,
  input wire logic       o_cal_start,
  input wire logic [2:0] o_cal_input,
  input wire logic       i_cal_done,
  input wire logic [9:0] i_cal_value,
  input wire logic [2:0] i_cal_read_input,
  input wire logic [9:0] o_stored_calibration_value,
  input wire logic       o_analog_calibration_failure_flag,
  input wire logic       i_cal_fail_irq_enable,
  input wire logic [7:0] i_touch_status,
  input wire logic       o_alert_n
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  // ==========================================================================
  // Pass tracking
  // A calibration pass is closed by the sampling or idling that follows it
  logic       pass_open;
  logic [2:0] last_cal;
  always_ff @(posedge i_mclk) begin
    if (i_reset || o_sample_start || o_low_power) pass_open <= 1'b0;
    else if (o_cal_start) pass_open <= 1'b1;
    if (o_cal_start) last_cal <= o_cal_input;
  end

  // ==========================================================================
  // Properties
  a_alert_idle: assert property (
    (i_touch_status == 8'h00 && !i_cal_fail_irq_enable) [*2] |-> o_alert_n)
    else $error("alert low with no cause");
  a_flag_alert: assert property (
    (o_analog_calibration_failure_flag && i_cal_fail_irq_enable) [*2] |-> !o_alert_n)
    else $error("enabled failure flag gives no alert");
  a_window_min: assert property (
    o_sample_start |=> !o_sample_start [*3]) else $error("sample window too short");
  a_input_hold: assert property (
    o_sample_start |=> $stable(o_sample_input) [*3]) else $error("input moved in window");
  a_idle_quiet: assert property (
    o_low_power |-> !o_sample_start && !o_cal_start) else $error("activity while idle");
  a_cal_pulse: assert property (
    o_cal_start |=> !o_cal_start && $stable(o_cal_input)) else $error("cal start not a pulse");
  a_store_write: assert property (
    (i_cal_done && i_cal_read_input == o_cal_input) ##1 $stable(i_cal_read_input)
    |=> o_stored_calibration_value == $past(i_cal_value, 2)) else $error("store not updated");
  a_cal_ascend: assert property (
    o_cal_start && pass_open |-> o_cal_input > last_cal) else $error("cal order not ascending");
endmodule : tsc_cycle_control_asserts

bind tsc_cycle_control tsc_cycle_control_asserts u_asserts (.i_mclk, .i_reset,
  .o_sample_start, .o_sample_input, .o_low_power, .o_cal_start, .o_cal_input, .i_cal_done,
  .i_cal_value, .i_cal_read_input, .o_stored_calibration_value,
  .o_analog_calibration_failure_flag, .i_cal_fail_irq_enable, .i_touch_status, .o_alert_n);

// [verification/tsc_front_end_model.sv]
// Behavioural analog front end: sample counts and calibration answers
`timescale 1ns/10ps

module tsc_front_end_model (
  input  wire logic        i_mclk,
  input  wire logic        i_reset,
  input  wire logic        i_sample_start,
  input  wire logic [2:0]  i_sample_input,
  input  wire logic        i_cal_start,
  input  wire logic [2:0]  i_cal_input,
  output logic             o_cal_done,
  output logic      [9:0]  o_cal_value,
  output logic      [7:0]  o_noise_flag,
  output logic      [15:0] o_sample_count
);
  logic [3:0] wait_cnt;
  logic       odd;
  logic [9:0] junk;
  always @(posedge i_mclk) begin
    if (i_reset) begin
      wait_cnt <= 4'h0;
      odd <= 1'b0;
      o_cal_done <= 1'b0;
      junk <= 10'h000;
    end else begin
      junk <= junk + 10'h05B;
      if (i_sample_start) odd <= !odd;
      o_cal_done <= (wait_cnt == 4'h1);
      if (i_cal_start) wait_cnt <= 4'h5;
      else if (wait_cnt != 4'h0) wait_cnt <= wait_cnt - 4'h1;
    end
  end
  // Input three is always noisy and input six sits at the limit, so both fail
  assign o_noise_flag = o_cal_done ? 8'h04 : junk[7:0];
  assign o_cal_value = !o_cal_done ? junk : (i_cal_input == 3'h5) ? 10'h3FF : {i_cal_input, 7'h15};
  // Alternating counts make an even-sized average land exactly on base plus one
  assign o_sample_count = {5'h00, i_sample_input, 8'h00} + (odd ? 16'h0002 : 16'h0000);
endmodule : tsc_front_end_model

// [verification/tb_tsc_cycle_control.sv]
// Self-checking bench for the touch cycle control
`timescale 1ns/10ps
`include "tsc_map.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
  $display("[FAIL] %0t got %h want %h", $time, (a), (b)); end end

module tb_tsc_cycle_control import tsc_pkg::*; ;
  localparam int SMP_UNIT = 4;
  localparam int CYC_UNIT = 200;
  logic        i_mclk = 1'b0, i_reset = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_wake = 1'b0;
  logic        i_cal_fail_clear = 1'b0, i_cal_fail_irq_enable = 1'b0;
  logic [7:0]  i_reg_addr = 8'h00, i_reg_wdata = 8'h00, i_touch_status = 8'h00;
  logic [2:0]  i_cal_read_input = 3'h0;
  logic        i_cal_done, o_sample_start, o_result_valid, o_low_power, o_cal_start, o_alert_n;
  logic        o_analog_calibration_failure_flag;
  logic [7:0]  o_reg_rdata, i_noise_flag;
  logic [2:0]  o_sample_input, o_result_input, o_cal_input;
  logic [9:0]  i_cal_value, o_stored_calibration_value;
  logic [15:0] i_sample_count, o_measured_result;
  logic [2:0]  calq[$];
  logic [18:0] resq[$];
  int          tq[$], nq[$];
  int          cyc_no = 0, nsamp = 0, mismatches = 0, tests_run = 0;
  logic [2:0]  last_in = 3'h7;
  logic        lp_seen = 1'b0;

  tsc_cycle_control #(.P_SAMPLE_UNIT_CYCLES(SMP_UNIT), .P_CYCLE_UNIT_CYCLES(CYC_UNIT)) DUT (
    .i_mclk, .i_reset, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_wake,
    .i_sample_count, .o_sample_start, .o_sample_input, .o_result_valid, .o_result_input,
    .o_measured_result, .o_low_power, .o_cal_start, .o_cal_input, .i_cal_done, .i_cal_value,
    .i_noise_flag, .i_cal_read_input, .o_stored_calibration_value,
    .o_analog_calibration_failure_flag, .i_cal_fail_clear, .i_cal_fail_irq_enable,
    .i_touch_status, .o_alert_n);

  tsc_front_end_model u_front (.i_mclk, .i_reset, .i_sample_start(o_sample_start),
    .i_sample_input(o_sample_input), .i_cal_start(o_cal_start), .i_cal_input(o_cal_input),
    .o_cal_done(i_cal_done), .o_cal_value(i_cal_value), .o_noise_flag(i_noise_flag),
    .o_sample_count(i_sample_count));

  always #12.5 i_mclk = ~i_mclk;

  // ==========================================================================
  // Monitor
  always @(posedge i_mclk) begin
    cyc_no <= cyc_no + 1;
    if (o_cal_start) calq.push_back(o_cal_input);
    if (o_result_valid) resq.push_back({o_result_input, o_measured_result});
    if (o_low_power) lp_seen <= 1'b1;
    if (o_sample_start) begin
      nsamp <= nsamp + 1;
      if (o_sample_input == 3'h0 && last_in != 3'h0) begin
        tq.push_back(cyc_no);
        nq.push_back(nsamp);
      end
      last_in <= o_sample_input;
    end
  end

  // ==========================================================================
  // Tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_mclk);
    i_reg_wr <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_mclk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_mclk);
    i_reg_rd <= 1'b0;
    #1 `CHK(o_reg_rdata, exp)
  endtask : rd_chk

  task automatic wait_cal(input int n);
    for (int k = 0; k < 3000 && calq.size() < n; k++) cyc(1);
  endtask : wait_cal

  // Skips the cycle in progress so only whole cycles are measured
  task automatic measure();
    tq.delete();
    nq.delete();
    for (int k = 0; k < 4000 && tq.size() < 2; k++) cyc(1);
    resq.delete();
    lp_seen = 1'b0;
    for (int k = 0; k < 4000 && tq.size() < 3; k++) cyc(1);
  endtask : measure

  task automatic finish_test();
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  initial begin
    #2500000;
    mismatches++;
    finish_test();
  end

  // ==========================================================================
  // Tests
  initial begin
    cyc(10);
    i_reset <= 1'b0;
    rd_chk(`TSC_ADDR_ACTIVE_ENABLE, 8'hFF);
    rd_chk(`TSC_ADDR_SAMPLING_SETUP, 8'h39);
    rd_chk(`TSC_ADDR_TOUCH_IRQ_EN, 8'hFF);
    rd_chk(8'h25, 8'h00);
    wr(`TSC_ADDR_SAMPLING_SETUP, 8'hFF);
    rd_chk(`TSC_ADDR_SAMPLING_SETUP, 8'h7F);
    wr(`TSC_ADDR_SAMPLING_SETUP, 8'h39);
    wait_cal(8);
    cyc(20);
    for (int k = 0; k < 8; k++) `CHK(calq[k], 3'(k))
    `CHK(o_analog_calibration_failure_flag, 1'b1)
    rd_chk(`TSC_ADDR_CAL_REQUEST, 8'h24);
    for (int k = 0; k < 8; k++) begin
      i_cal_read_input <= 3'(k);
      cyc(2);
      #1 `CHK(o_stored_calibration_value, (k == 5) ? 10'h3FF : {3'(k), 7'h15})
    end
    cyc(3);
    #1 `CHK(o_alert_n, 1'b1)
    i_cal_fail_irq_enable <= 1'b1;
    cyc(3);
    #1 `CHK(o_alert_n, 1'b0)
    i_cal_fail_clear <= 1'b1;
    cyc(1);
    i_cal_fail_clear <= 1'b0;
    i_cal_fail_irq_enable <= 1'b0;
    cyc(3);
    #1 `CHK(o_analog_calibration_failure_flag, 1'b0)
    wr(`TSC_ADDR_TOUCH_IRQ_EN, 8'h01);
    i_touch_status <= 8'h02;
    cyc(3);
    #1 `CHK(o_alert_n, 1'b1)
    i_touch_status <= 8'h01;
    cyc(3);
    #1 `CHK(o_alert_n, 1'b0)
    i_touch_status <= 8'h00;
    wr(`TSC_ADDR_CAL_REQUEST, 8'h00);
    calq.delete();
    wr(`TSC_ADDR_CAL_REQUEST, 8'h81);
    wr(`TSC_ADDR_CAL_REQUEST, 8'h01);
    wait_cal(1);
    cyc(1500);
    `CHK(calq.size(), 1)
    `CHK(calq[0], 3'h0)
    rd_chk(`TSC_ADDR_CAL_REQUEST, 8'h00);
    wr(`TSC_ADDR_ACTIVE_ENABLE, 8'h04);
    wr(`TSC_ADDR_ACTIVE_ENABLE, 8'h05);
    rd_chk(`TSC_ADDR_CAL_REQUEST, 8'h01);
    // One sample of four cycles per input, period code one
    wr(`TSC_ADDR_SAMPLING_SETUP, 8'h01);
    measure();
    `CHK(tq[2] - tq[1], 2 * CYC_UNIT)
    `CHK(nq[2] - nq[1], 2)
    `CHK(lp_seen, 1'b1)
    `CHK(resq[0][18:16], 3'h0)
    `CHK(resq[1][18:16], 3'h2)
    // Eight samples of the longest duration overrun the shortest period
    wr(`TSC_ADDR_SAMPLING_SETUP, 8'h3C);
    measure();
    `CHK(tq[2] - tq[1] >= 2 * 8 * (SMP_UNIT << 3), 1'b1)
    `CHK(nq[2] - nq[1], 16)
    `CHK(lp_seen, 1'b0)
    `CHK(resq[0], {3'h0, 16'h0001})
    `CHK(resq[1], {3'h2, 16'h0201})
    calq.delete();
    i_wake <= 1'b1;
    cyc(1);
    i_wake <= 1'b0;
    wait_cal(2);
    `CHK(calq[0], 3'h0)
    `CHK(calq[1], 3'h2)
    finish_test();
  end
endmodule : tb_tsc_cycle_control
